// ==== tb/rtc_event_timestamp_capture_tb_top.sv ====
`timescale 1ns/100ps
module rtc_event_timestamp_capture_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic event_input = 1'b0;
  logic bkp = 1'b0;
  logic [6:0] secs = 7'h00;
  logic en = 1'b0;
  logic ovw = 1'b0;
  logic sel = 1'b1;
  logic trst = 1'b0;
  logic held = 1'b0;
  logic exp_c = 1'b0;
  logic [7:0] exp_t = 8'h00;
  logic [6:0] exp_s = 7'h00;
  logic [7:0] addr, wdata, rdata, tally, capt, d;
  logic rd, wr, cpulse;
  integer seed = 32'h0C848363;
  int n_errors = 0;
  int n_checks = 0;
  always #20 core_clk = ~core_clk;
  rtcts_core i_dut (.core_clk(core_clk), .rstn(rstn), .event_input(event_input),
    .backup_switch_pulse(bkp), .seconds_bcd(secs), .timestamp_enable(en),
    .timestamp_overwrite(ovw), .timestamp_source_select(sel), .timestamp_reset(trst),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
    .event_tally(tally), .captured_seconds_value(capt), .capture_pulse(cpulse));
  rtcts_host i_host (.core_clk(core_clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata));
  // ----
  // Checking and model
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    if (trst) begin
      exp_t = 8'h00;
      exp_s = 7'h00;
      held = 1'b0;
    end
    exp_c = 1'b0;
    if (en && sel && bkp) begin
      exp_t = exp_t + 8'h01;
      if (ovw || !held) begin
        exp_s = secs;
        exp_c = 1'b1;
      end
      held = 1'b1;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    i_host.acc(1'b0, 8'h14, 8'h00, d);
    chk(d, 8'h00);
    i_host.acc(1'b0, 8'h15, 8'h00, d);
    chk(d, 8'h00);
    for (int i = 0; i < 1500; i++) begin
      @(posedge core_clk);
      step();
      bkp <= ($random(seed) & 3) != 0;
      en <= ($random(seed) & 15) != 0;
      sel <= ($random(seed) & 3) != 0;
      ovw <= 1'($random(seed));
      trst <= (i > 600) && (($random(seed) & 63) == 0);
      secs <= {3'($unsigned($random(seed)) % 6), 4'($unsigned($random(seed)) % 10)};
      @(negedge core_clk);
      chk(tally, exp_t);
      chk(capt, {1'b0, exp_s});
      chk({7'h00, cpulse}, {7'h00, exp_c});
    end
    @(posedge core_clk);
    step();
    en <= 1'b0;
    bkp <= 1'b0;
    trst <= 1'b0;
    i_host.acc(1'b0, 8'h14, 8'h00, d);
    chk(d, exp_t);
    i_host.acc(1'b1, 8'h14, 8'hFF, d);
    i_host.acc(1'b1, 8'h15, 8'hFF, d);
    i_host.acc(1'b0, 8'h14, 8'h00, d);
    chk(d, exp_t);
    i_host.acc(1'b0, 8'h15, 8'h00, d);
    chk(d, {1'b0, exp_s});
    i_host.acc(1'b0, 8'h20, 8'h00, d);
    chk(d, 8'h00);
    ovw <= 1'b1;
    sel <= 1'b0;
    en <= 1'b1;
    secs <= 7'h42;
    event_input <= 1'b1;
    for (int i = 0; i < 8 && cpulse !== 1'b1; i++) @(negedge core_clk);
    chk({7'h00, cpulse}, 8'h01);
    chk(tally, exp_t + 8'h01);
    chk(capt, 8'h42);
    tally_and_finish();
  end
endmodule

// ==== tb/rtcts_host.sv ====
`timescale 1ns/100ps
module rtcts_host (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One byte access, entered at a rising edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
endmodule

// ==== verilog/rtcts_core.sv ====
`timescale 1ns/100ps
// How it works
// - Count selected events in plain binary
// - Eight-bit tally spanning zero to 255
// - Both registers ignore host writes
// - Copy running BCD seconds on event
// - Seconds 00..59, bit seven reads zero
// - Source select picks pin or backup
// - Events ignored while enable is clear; reset strobe still clears
// - Overwrite picks first or latest capture
// - Reset strobe clears tally and seconds
module rtcts_core (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic event_input,
  input wire logic backup_switch_pulse,
  input wire logic [rtcts_pkg::SEC_W-1:0] seconds_bcd,
  input wire logic timestamp_enable,
  input wire logic timestamp_overwrite,
  input wire logic timestamp_source_select,
  input wire logic timestamp_reset,
  input wire logic [rtcts_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [rtcts_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [rtcts_pkg::DATA_W-1:0] reg_rdata,
  output logic [rtcts_pkg::DATA_W-1:0] event_tally,
  output logic [rtcts_pkg::DATA_W-1:0] captured_seconds_value,
  output logic capture_pulse
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] tally;
    logic [6:0] seconds;
    logic held;
    logic [7:0] rdata;
    logic capt;
  } rtcts_state_t;

  rtcts_state_t st_r;
  rtcts_state_t st_nxt;
  logic pin_event;
  logic qual_event;
  logic [7:0] base_tally;
  logic [6:0] base_seconds;
  logic base_held;
  logic unused_wr;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] tally,
                                          input logic [6:0] secs);
    logic [7:0] val;
    val = rtcts_pkg::READ_IDLE;
    if (addr == rtcts_pkg::ADDR_EVENT_COUNT) begin
      val = tally;
    end else if (addr == rtcts_pkg::ADDR_CAPT_SECONDS) begin
      val = {rtcts_pkg::SEC_PAD_BIT, secs};
    end
    return val;
  endfunction

  // ----------------------------------------
  // Event source
  // ----------------------------------------
  rtcts_sync_edge #(
    .FALLING(1'b0)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_in(event_input),
    .edge_pulse(pin_event)
  );

  always_comb begin
    qual_event = 1'b0;
    if (timestamp_enable) begin
      qual_event = (timestamp_source_select == rtcts_pkg::SRC_BACKUP) ?
                   backup_switch_pulse : pin_event;
    end
  end

  // Host writes land on read-only registers and are dropped
  assign unused_wr = reg_wr & (|reg_wdata);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    base_tally = timestamp_reset ? rtcts_pkg::TALLY_RST : st_r.tally;
    base_seconds = timestamp_reset ? rtcts_pkg::SEC_RST : st_r.seconds;
    base_held = timestamp_reset ? 1'b0 : st_r.held;
    st_nxt.tally = base_tally;
    st_nxt.seconds = base_seconds;
    st_nxt.held = base_held;
    st_nxt.capt = 1'b0;
    if (qual_event) begin
      st_nxt.tally = 8'(base_tally + rtcts_pkg::TALLY_STEP);
      if (timestamp_overwrite || !base_held) begin
        st_nxt.seconds = seconds_bcd;
        st_nxt.held = 1'b1;
        st_nxt.capt = 1'b1;
      end
    end
    if (reg_rd) begin
      st_nxt.rdata = read_mux(reg_addr, st_r.tally, st_r.seconds);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.tally <= rtcts_pkg::TALLY_RST;
      st_r.seconds <= rtcts_pkg::SEC_RST;
      st_r.held <= 1'b0;
      st_r.rdata <= rtcts_pkg::READ_IDLE;
      st_r.capt <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = st_r.rdata;
  assign event_tally = st_r.tally;
  assign captured_seconds_value = {rtcts_pkg::SEC_PAD_BIT, st_r.seconds};
  assign capture_pulse = st_r.capt;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_tally_counts_up: assert property (
    qual_event && !timestamp_reset |=> event_tally == 8'($past(event_tally) + 8'h01))
    else $error("tally did not count the event");

  a_tally_wraps_zero: assert property (
    qual_event && !timestamp_reset && event_tally == rtcts_pkg::TALLY_MAX
    |=> event_tally == rtcts_pkg::TALLY_RST)
    else $error("tally did not wrap to zero");

  a_write_no_effect: assert property (
    reg_wr && !qual_event && !timestamp_reset
    |=> $stable(event_tally) && $stable(captured_seconds_value))
    else $error("host write changed a read-only register");

  a_seconds_copy: assert property (
    qual_event && timestamp_overwrite
    |=> captured_seconds_value[6:0] == $past(seconds_bcd) && capture_pulse)
    else $error("seconds not captured on event");

  a_read_pad_zero: assert property (
    reg_rd && reg_addr == rtcts_pkg::ADDR_CAPT_SECONDS
    |=> reg_rdata[7] == 1'b0 && reg_rdata == $past(captured_seconds_value))
    else $error("seconds read wrong");

  a_backup_source: assert property (
    timestamp_enable && timestamp_source_select && backup_switch_pulse && !timestamp_reset
    |=> event_tally == 8'($past(event_tally) + 8'h01))
    else $error("backup event not counted");

  a_disabled_frozen: assert property (
    !timestamp_enable && !timestamp_reset
    |=> $stable(event_tally) && $stable(captured_seconds_value) && !capture_pulse)
    else $error("update while disabled");

  a_first_kept: assert property (
    !timestamp_overwrite && st_r.held && qual_event && !timestamp_reset
    |=> $stable(captured_seconds_value) && !capture_pulse)
    else $error("first capture overwritten");

  a_reset_clears: assert property (
    timestamp_reset && !qual_event
    |=> event_tally == rtcts_pkg::TALLY_RST && captured_seconds_value == 8'h00)
    else $error("reset strobe did not clear");

  a_read_count: assert property (
    reg_rd && reg_addr == rtcts_pkg::ADDR_EVENT_COUNT |=> reg_rdata == $past(event_tally))
    else $error("count read wrong");

  a_pin_source: assert property (
    timestamp_enable && timestamp_source_select == rtcts_pkg::SRC_EVENT_PIN && pin_event
    && !timestamp_reset |=> event_tally == 8'($past(event_tally) + rtcts_pkg::TALLY_STEP))
    else $error("pin event not counted");

  a_pin_sel_only: assert property (
    timestamp_enable && timestamp_source_select == rtcts_pkg::SRC_EVENT_PIN && !pin_event
    && !timestamp_reset |=> $stable(event_tally))
    else $error("backup pulse counted with pin source");

  a_backup_sel_only: assert property (
    timestamp_enable && timestamp_source_select == rtcts_pkg::SRC_BACKUP && !backup_switch_pulse
    && !timestamp_reset |=> $stable(event_tally))
    else $error("pin event counted with backup source");

  a_first_after_clear: assert property (
    qual_event && !timestamp_overwrite && !st_r.held
    |=> capture_pulse && captured_seconds_value[6:0] == $past(seconds_bcd))
    else $error("first capture after clear missed");

  a_event_beats_clear: assert property (
    qual_event && timestamp_reset
    |=> event_tally == rtcts_pkg::TALLY_STEP && capture_pulse)
    else $error("event lost against reset strobe");

  a_pulse_needs_event: assert property (
    !qual_event |=> !capture_pulse)
    else $error("capture pulse without event");

  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_unmapped_idle: assert property (
    reg_rd && reg_addr != rtcts_pkg::ADDR_EVENT_COUNT
    && reg_addr != rtcts_pkg::ADDR_CAPT_SECONDS |=> reg_rdata == rtcts_pkg::READ_IDLE)
    else $error("unmapped read not idle");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_pin_capture: cover property (pin_event && timestamp_enable && !timestamp_source_select);
  c_tally_wrap: cover property (qual_event && event_tally == rtcts_pkg::TALLY_MAX);
  c_overwrite_capture: cover property (qual_event && timestamp_overwrite && st_r.held);
  c_first_kept: cover property (qual_event && !timestamp_overwrite && st_r.held);
  c_reset_with_event: cover property (qual_event && timestamp_reset);
endmodule

// ==== verilog/rtcts_pkg.sv ====
package rtcts_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SEC_W = 7;
  localparam logic [7:0] ADDR_EVENT_COUNT = 8'h14;
  localparam logic [7:0] ADDR_CAPT_SECONDS = 8'h15;
  // ----------------------------------------
  // Reset and fixed values
  // ----------------------------------------
  localparam logic [7:0] TALLY_RST = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  localparam logic [7:0] TALLY_STEP = 8'h01;
  localparam logic [6:0] SEC_RST = 7'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic SEC_PAD_BIT = 1'b0;
  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  localparam logic SRC_EVENT_PIN = 1'b0;
  localparam logic SRC_BACKUP = 1'b1;
endpackage

// ==== verilog/rtcts_sync_edge.sv ====
`timescale 1ns/100ps
module rtcts_sync_edge #(
  parameter bit FALLING = 1'b0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pin_in,
  output logic edge_pulse
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } rtcts_sync_t;

  rtcts_sync_t st_r;
  rtcts_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.pulse = FALLING ? (st_r.s3 & ~st_r.s2) : (st_r.s2 & ~st_r.s3);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_pulse = st_r.pulse;
endmodule
